//--- inc/codec_slot_regs.vh
// Purpose: Shared constants of the time-slot serial port.
// Assumes: System clock of 25 MHz.
// Notes: Timing counts follow from the system and bit clock periods.
`ifndef CODEC_SLOT_REGS_VH
`define CODEC_SLOT_REGS_VH

`define CLK_PERIOD_NS 40
`define BCLK_PERIOD_NS 320
`define BCLK_HALF_CYCLES (`BCLK_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`define DIV_W 4

`define BITS_PER_FRAME 256
`define LAST_BIT 8'hFF
`define SLOT_BITS 16
`define WORD_W 16
`define LAST_SLOT_BIT 4'hF

`define CTRL_RX_SLOT 4'h0
`define CTRL_TX_SLOT 4'h1
`define FIRST_DATA_SLOT 4'h2

`define KIND_NONE 2'h0
`define KIND_CH1 2'h1
`define KIND_CH2 2'h2
`define KIND_CTRL 2'h3

`define BUF_W 18

`endif

//--- rtl/slot_buffer.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Full takes no write even if the reader pops in the same cycle.
`timescale 1ns/1ps

module slot_buffer
#(
    parameter WIDTH = 18
)
(
    input wire i_clk,
    input wire i_reset_n,
    input wire i_in_valid,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_in_ready,
    output wire o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input wire i_out_ready
);

reg [WIDTH-1:0] mem_q [0:1];
reg wr_ptr_q;
reg rd_ptr_q;
reg [1:0] count_q;
wire push;
wire pop;

assign o_in_ready = (count_q != 2'h2);
assign o_out_valid = (count_q != 2'h0);
assign o_out_data = mem_q[rd_ptr_q];
assign push = i_in_valid && o_in_ready;
assign pop = o_out_valid && i_out_ready;

always @(posedge i_clk)
begin
    if (!i_reset_n)
    begin
        wr_ptr_q <= 1'b0;
        rd_ptr_q <= 1'b0;
        count_q <= 2'h0;
        mem_q[0] <= {WIDTH{1'b0}};
        mem_q[1] <= {WIDTH{1'b0}};
    end
    else
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= i_in_data;
            wr_ptr_q <= ~wr_ptr_q;
        end
        if (pop)
        begin
            rd_ptr_q <= ~rd_ptr_q;
        end
        if (push && !pop)
        begin
            count_q <= count_q + 2'h1;
        end
        else if (pop && !push)
        begin
            count_q <= count_q - 2'h1;
        end
    end
end

endmodule

//--- rtl/codec_slot_port.v
// Purpose: Time-slot serial data port of a dual voice codec.
// Assumes: Bit clock, frame sync and data pins are asynchronous to i_clk.
// Notes: Slave bit clock must stay below i_clk / 6 for edge detection.
//
// Behaviour
// - Bit clock shifts data in and out.
// - Master drives bit clock, 256 per frame.
// - Playback/register in, capture/register out.
// - Capture on falling edge, own slots only.
// - Channel 1 first slot, channel 2 second.
// - Output changes on rising edge, own slots.
// - Output high impedance in foreign slots.
// - Channel 1 sends first, channel 2 second.
// - Frame sync marks frame and slot 0.
// - Sample frame sync on rising edge.
// - Master drives frame sync, slave receives.
// - Straps pick slot pair, upper bit MSB.
// - Control select low: slots 0/1 register traffic.
`timescale 1ns/1ps
`include "codec_slot_regs.vh"

module codec_slot_port
(
    input wire i_clk,
    input wire i_reset_n,
    input wire i_master,
    input wire i_ctrl_sel,
    input wire i_slot_strap_high,
    input wire i_slot_strap_low,
    input wire i_bclk,
    output wire o_bclk,
    output wire o_bclk_oe_n,
    input wire i_frame_sync,
    output wire o_frame_sync,
    output wire o_frame_sync_oe_n,
    input wire i_din,
    output wire o_dout,
    output wire o_dout_oe_n,
    output wire o_rx_valid,
    output wire [1:0] o_rx_kind,
    output wire [15:0] o_rx_data,
    input wire i_rx_ready,
    output wire o_rx_overrun,
    input wire i_cap_wr,
    input wire i_cap_ch2,
    input wire [15:0] i_cap_data,
    input wire i_ctrl_tx_valid,
    input wire [15:0] i_ctrl_tx_data,
    output wire o_ctrl_tx_ready,
    output wire o_frame_start
);

////////////////////////////////////////////////////////////////////////////////
// Slot decode

// Kind of a slot for this device; control slot is direction specific
function [1:0] slot_kind;
    input [3:0] slot;
    input [1:0] addr;
    input ctrl_slot_used;
    input [3:0] ctrl_slot;
    input [3:0] this_slot;
    reg [3:0] base;
    begin
        base = `FIRST_DATA_SLOT + {1'b0, addr, 1'b0};
        slot_kind = `KIND_NONE;
        if (slot == base)
        begin
            slot_kind = `KIND_CH1;
        end
        else if (slot == base + 4'h1)
        begin
            slot_kind = `KIND_CH2;
        end
        else if (ctrl_slot_used && (this_slot == ctrl_slot))
        begin
            slot_kind = `KIND_CTRL;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg [5:0] sync1_q;
reg [5:0] sync2_q;
reg bclk_s3_q;
wire bclk_s;
wire fs_s;
wire din_s;
wire master_s;
wire ctrl_sel_s;
wire [1:0] addr_s;

always @(posedge i_clk)
begin
    if (!i_reset_n)
    begin
        sync1_q <= 6'h00;
        sync2_q <= 6'h00;
        bclk_s3_q <= 1'b0;
    end
    else
    begin
        sync1_q <= {i_bclk, i_frame_sync, i_din, i_master, i_ctrl_sel,
                    i_slot_strap_high};
        sync2_q <= sync1_q;
        bclk_s3_q <= sync2_q[5];
    end
end

reg strap_low_s1_q;
reg strap_low_s2_q;

always @(posedge i_clk)
begin
    if (!i_reset_n)
    begin
        strap_low_s1_q <= 1'b0;
        strap_low_s2_q <= 1'b0;
    end
    else
    begin
        strap_low_s1_q <= i_slot_strap_low;
        strap_low_s2_q <= strap_low_s1_q;
    end
end

assign bclk_s = sync2_q[5];
assign fs_s = sync2_q[4];
assign din_s = sync2_q[3];
assign master_s = sync2_q[2];
assign ctrl_sel_s = sync2_q[1];
assign addr_s = {sync2_q[0], strap_low_s2_q};

////////////////////////////////////////////////////////////////////////////////
// Master bit clock divider and frame sync

reg [`DIV_W-1:0] div_q;
reg bclk_q;
reg fs_q;
reg [7:0] bit_cnt_q;
reg frame_ok_q;
wire div_end;
wire m_rise;
wire m_fall;
wire rise;
wire fall;
wire fs_now;

assign div_end = (div_q == `BCLK_HALF_CYCLES - 1);
assign m_rise = div_end && !bclk_q;
assign m_fall = div_end && bclk_q;
// Slave edges come from the pin; the third stage only delays for the compare
assign rise = master_s ? m_rise : (bclk_s && !bclk_s3_q);
assign fall = master_s ? m_fall : (!bclk_s && bclk_s3_q);
assign fs_now = master_s ? fs_q : fs_s;

always @(posedge i_clk)
begin
    if (!i_reset_n)
    begin
        div_q <= {`DIV_W{1'b0}};
        bclk_q <= 1'b0;
        fs_q <= 1'b0;
    end
    else if (!master_s)
    begin
        div_q <= {`DIV_W{1'b0}};
        bclk_q <= 1'b0;
        fs_q <= 1'b0;
    end
    else
    begin
        if (div_end)
        begin
            div_q <= {`DIV_W{1'b0}};
            bclk_q <= ~bclk_q;
        end
        else
        begin
            div_q <= div_q + 4'h1;
        end
        // Raised half a bit early so the far party sees it at the rising edge
        if (m_fall)
        begin
            fs_q <= (bit_cnt_q == `LAST_BIT);
        end
    end
end

assign o_bclk = bclk_q;
assign o_bclk_oe_n = !master_s;
assign o_frame_sync = fs_q;
assign o_frame_sync_oe_n = !master_s;

////////////////////////////////////////////////////////////////////////////////
// Frame position

wire [7:0] next_cnt;
wire [3:0] next_slot;
wire [3:0] next_bit;
wire [3:0] cur_slot;
wire [3:0] cur_bit;

assign next_cnt = fs_now ? 8'h00 : bit_cnt_q + 8'h01;
assign next_slot = next_cnt[7:4];
assign next_bit = next_cnt[3:0];
assign cur_slot = bit_cnt_q[7:4];
assign cur_bit = bit_cnt_q[3:0];

always @(posedge i_clk)
begin
    if (!i_reset_n)
    begin
        bit_cnt_q <= `LAST_BIT;
        frame_ok_q <= 1'b0;
    end
    else if (rise)
    begin
        bit_cnt_q <= next_cnt;
        if (fs_now)
        begin
            frame_ok_q <= 1'b1;
        end
    end
end

assign o_frame_start = rise && fs_now;

////////////////////////////////////////////////////////////////////////////////
// Transmit path

reg [15:0] cap1_q;
reg [15:0] cap2_q;
reg [15:0] ctrl_tx_q;
reg ctrl_pend_q;
reg [15:0] tx_sh_q;
reg dout_q;
reg dout_oe_n_q;
reg [15:0] tx_word;
reg ctrl_on_q;
wire ctrl_use;
wire [1:0] tx_kind;

// Slot 1 is only driven when a reply is waiting, since devices share it;
// pending clears at the first bit, so the slot is held by ctrl_on_q after
assign ctrl_use = !ctrl_sel_s && ((next_bit == 4'h0) ? ctrl_pend_q : ctrl_on_q);
assign tx_kind = slot_kind(next_slot, addr_s, ctrl_use,
                           `CTRL_TX_SLOT, next_slot);
assign o_ctrl_tx_ready = !ctrl_pend_q;

always @*
begin
    tx_word = 16'h0000;
    case (tx_kind)
        `KIND_CH1: tx_word = cap1_q;
        `KIND_CH2: tx_word = cap2_q;
        `KIND_CTRL: tx_word = ctrl_tx_q;
        default: tx_word = 16'h0000;
    endcase
end

always @(posedge i_clk)
begin
    if (!i_reset_n)
    begin
        cap1_q <= 16'h0000;
        cap2_q <= 16'h0000;
        ctrl_tx_q <= 16'h0000;
        ctrl_pend_q <= 1'b0;
        ctrl_on_q <= 1'b0;
        tx_sh_q <= 16'h0000;
        dout_q <= 1'b0;
        dout_oe_n_q <= 1'b1;
    end
    else
    begin
        if (i_cap_wr && !i_cap_ch2)
        begin
            cap1_q <= i_cap_data;
        end
        if (i_cap_wr && i_cap_ch2)
        begin
            cap2_q <= i_cap_data;
        end
        if (rise && (frame_ok_q || fs_now) && next_bit == 4'h0 &&
            tx_kind == `KIND_CTRL)
        begin
            ctrl_pend_q <= 1'b0;
        end
        else if (i_ctrl_tx_valid && !ctrl_pend_q)
        begin
            ctrl_tx_q <= i_ctrl_tx_data;
            ctrl_pend_q <= 1'b1;
        end
        if (rise)
        begin
            ctrl_on_q <= (frame_ok_q || fs_now) && (tx_kind == `KIND_CTRL);
            if (!(frame_ok_q || fs_now) || tx_kind == `KIND_NONE)
            begin
                dout_oe_n_q <= 1'b1;
            end
            else if (next_bit == 4'h0)
            begin
                dout_q <= tx_word[15];
                tx_sh_q <= {tx_word[14:0], 1'b0};
                dout_oe_n_q <= 1'b0;
            end
            else
            begin
                dout_q <= tx_sh_q[15];
                tx_sh_q <= {tx_sh_q[14:0], 1'b0};
                dout_oe_n_q <= 1'b0;
            end
        end
    end
end

assign o_dout = dout_q;
assign o_dout_oe_n = dout_oe_n_q;

////////////////////////////////////////////////////////////////////////////////
// Receive path

reg [15:0] rx_sh_q;
reg push_q;
reg [`BUF_W-1:0] push_data_q;
reg overrun_q;
wire [1:0] rx_kind;
wire buf_ready;
wire [`BUF_W-1:0] buf_data;

assign rx_kind = slot_kind(cur_slot, addr_s, !ctrl_sel_s, `CTRL_RX_SLOT,
                           cur_slot);

always @(posedge i_clk)
begin
    if (!i_reset_n)
    begin
        rx_sh_q <= 16'h0000;
        push_q <= 1'b0;
        push_data_q <= {`BUF_W{1'b0}};
        overrun_q <= 1'b0;
    end
    else
    begin
        push_q <= 1'b0;
        overrun_q <= 1'b0;
        if (fall && frame_ok_q && rx_kind != `KIND_NONE)
        begin
            rx_sh_q <= {rx_sh_q[14:0], din_s};
            if (cur_bit == `LAST_SLOT_BIT)
            begin
                push_data_q <= {rx_kind, rx_sh_q[14:0], din_s};
                push_q <= buf_ready;
                overrun_q <= !buf_ready;
            end
        end
    end
end

slot_buffer
#(
    .WIDTH(`BUF_W)
)
u_rx_buffer
(
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(push_q),
    .i_in_data(push_data_q),
    .o_in_ready(buf_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(buf_data),
    .i_out_ready(i_rx_ready)
);

assign o_rx_kind = buf_data[17:16];
assign o_rx_data = buf_data[15:0];
assign o_rx_overrun = overrun_q;

endmodule

//--- dv/codec_slot_port_sva.sv
// Purpose: Port-level checks of the slot serial port.
// Assumes: Single clock domain, reset active low.
// Notes: Frame length is counted only from the first master frame sync.
`timescale 1ns/1ps
module codec_slot_port_sva
(
    input wire i_clk,
    input wire i_reset_n,
    input wire i_master,
    input wire i_rx_ready,
    input wire i_ctrl_tx_valid,
    input wire o_bclk,
    input wire o_bclk_oe_n,
    input wire o_frame_sync,
    input wire o_frame_sync_oe_n,
    input wire o_rx_valid,
    input wire [1:0] o_rx_kind,
    input wire [15:0] o_rx_data,
    input wire o_rx_overrun,
    input wire o_ctrl_tx_ready,
    input wire o_frame_start
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    reg bclk_q;
    reg fs_q;
    reg seen_q;
    reg [8:0] rise_q;
    ////////////////////////////////////////////////////////////////
    // First frame after entering master is partial, so skipped
    always @(posedge i_clk)
    begin
        bclk_q <= o_bclk;
        fs_q <= o_frame_sync;
        if (!i_reset_n || o_bclk_oe_n)
        begin
            rise_q <= 9'h000;
            seen_q <= 1'b0;
        end
        else if (o_frame_sync && !fs_q)
        begin
            rise_q <= 9'h000;
            seen_q <= 1'b1;
        end
        else if (o_bclk && !bclk_q)
            rise_q <= rise_q + 9'h001;
    end
    ////////////////////////////////////////////////////////////////
    a_slave_released: assert property ((!i_master)[*4] |-> o_bclk_oe_n && !o_bclk)
        else $error("bit clock driven in slave mode");
    a_master_drives: assert property (i_master[*4] |->
        !o_bclk_oe_n && !o_frame_sync_oe_n)
        else $error("master not driving clock and sync");
    a_bclk_half: assert property ($rose(o_bclk) |-> o_bclk[*4] ##1 !o_bclk)
        else $error("bit clock half period wrong");
    a_frame_length: assert property (o_frame_sync && !fs_q && seen_q |->
        rise_q == 9'h100)
        else $error("frame not 256 bit clocks");
    a_sync_one_bit: assert property ($rose(o_frame_sync) |->
        o_frame_sync[*8] ##1 !o_frame_sync)
        else $error("frame sync not one bit long");
    a_start_in_sync: assert property (o_frame_start && !o_frame_sync_oe_n |->
        o_frame_sync)
        else $error("frame start without frame sync");
    a_rx_word_hold: assert property (o_rx_valid && !i_rx_ready |=>
        o_rx_valid && $stable(o_rx_data) && $stable(o_rx_kind))
        else $error("stalled word changed");
    a_overrun_full: assert property (o_rx_overrun |-> o_rx_valid)
        else $error("overrun while buffer not full");
    a_kind_known: assert property (o_rx_valid |-> o_rx_kind != 2'h0)
        else $error("received word without kind");
    a_reply_taken: assert property (i_ctrl_tx_valid && o_ctrl_tx_ready |=>
        !o_ctrl_tx_ready)
        else $error("reply taken but ready stays high");
endmodule
bind codec_slot_port codec_slot_port_sva codec_slot_port_sva_i (.i_clk, .i_reset_n, .i_master,
    .i_rx_ready, .i_ctrl_tx_valid, .o_bclk, .o_bclk_oe_n, .o_frame_sync, .o_frame_sync_oe_n,
    .o_rx_valid, .o_rx_kind, .o_rx_data, .o_rx_overrun, .o_ctrl_tx_ready, .o_frame_start);

//--- dv/dsp_port_model.sv
// Purpose: Far-side serial port: bit clock, frame sync, data.
// Assumes: Slave codec; sends {base, slot} in every slot.
// Notes: Samples the output at the next rise for settling margin.
`timescale 1ns/1ps
module dsp_port_model
(
    input wire [11:0] i_base,
    input wire i_dout,
    input wire i_dout_oe_n,
    output reg o_bclk,
    output reg o_fs,
    output reg o_din,
    output reg [19:0] o_got,
    output reg o_got_tgl
);
    reg [7:0] cnt;
    reg [15:0] sh;
    reg [15:0] w;
    reg own;
    initial
    begin
        {o_bclk, o_fs, o_din, o_got_tgl, own} = 5'h00;
        cnt = 8'hFE;
        #37;
        forever #160 o_bclk = ~o_bclk;
    end
    always @(negedge o_bclk)
        o_fs = (cnt == 8'hFF);
    always @(posedge o_bclk)
    begin
        // Released line shows a toggling pattern, not the last bit
        sh = {sh[14:0], i_dout_oe_n ? cnt[0] : i_dout};
        own = (cnt[3:0] == 4'h0 ? 1'b0 : own) | !i_dout_oe_n;
        if (cnt[3:0] == 4'hF && own)
        begin
            o_got = {cnt[7:4], sh};
            o_got_tgl = ~o_got_tgl;
        end
        cnt = cnt + 8'h01;
        w = {i_base, cnt[7:4]};
        o_din = w[4'hF - cnt[3:0]];
    end
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench of the slot serial port.
// Assumes: Slave traffic from the model, short master run at end.
// Notes: Only the middle frame of three is scored.
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg master = 1'b0;
    reg ctrl_sel = 1'b0;
    reg st_hi = 1'b0;
    reg st_lo = 1'b0;
    reg rx_ready = 1'b1;
    reg cap_wr = 1'b0;
    reg cap_ch2 = 1'b0;
    reg [15:0] cap_data = 16'h0000;
    reg ctx_valid = 1'b0;
    reg [15:0] ctx_data = 16'h0000;
    reg [11:0] base = 12'h000;
    reg listen = 1'b0;
    reg [15:0] c1, c2, r;
    reg [3:0] slot;
    wire bclk, fs, din, dout, dout_oe_n, bclk_oe_n;
    wire rx_valid, ovr, ctx_ready, fstart, got_tgl;
    wire [1:0] rx_kind;
    wire [15:0] rx_data;
    wire [19:0] got;
    integer seed = 72, num_errors = 0, check_count = 0, n_ovr = 0, i;
    reg [17:0] rq[$];
    reg [19:0] dq[$];
    always #20 clk = ~clk;
    codec_slot_port codec_slot_port_i (.i_clk(clk), .i_reset_n(rst_n), .i_master(master),
        .i_ctrl_sel(ctrl_sel), .i_slot_strap_high(st_hi), .i_slot_strap_low(st_lo),
        .i_bclk(bclk), .o_bclk(), .o_bclk_oe_n(bclk_oe_n), .i_frame_sync(fs),
        .o_frame_sync(), .o_frame_sync_oe_n(), .i_din(din), .o_dout(dout),
        .o_dout_oe_n(dout_oe_n), .o_rx_valid(rx_valid), .o_rx_kind(rx_kind),
        .o_rx_data(rx_data), .i_rx_ready(rx_ready), .o_rx_overrun(ovr), .i_cap_wr(cap_wr),
        .i_cap_ch2(cap_ch2), .i_cap_data(cap_data), .i_ctrl_tx_valid(ctx_valid),
        .i_ctrl_tx_data(ctx_data), .o_ctrl_tx_ready(ctx_ready), .o_frame_start(fstart));
    dsp_port_model dsp_port_model_i (.i_base(base), .i_dout(dout), .i_dout_oe_n(dout_oe_n),
        .o_bclk(bclk), .o_fs(fs), .o_din(din), .o_got(got), .o_got_tgl(got_tgl));
    ////////////////////////////////////////////////////////////////
    task chk_word(input [47:0] nm, input [19:0] e, input [19:0] s);
    begin
        check_count = check_count + 1;
        if (s !== e)
        begin
            num_errors = num_errors + 1;
            $display("BAD %0s exp %h seen %h", nm, e, s);
        end
    end
    endtask
    task chk_flag(input [47:0] nm, input [31:0] e, input [31:0] s);
    begin
        check_count = check_count + 1;
        if (s !== e)
        begin
            num_errors = num_errors + 1;
            $display("BAD %0s exp %0d seen %0d", nm, e, s);
        end
    end
    endtask
    task tally_and_finish;
    begin
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task step(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask
    task frame;
        integer k;
    begin
        k = 0;
        while (fstart !== 1'b1 && k < 3000)
        begin
            step(1);
            k = k + 1;
        end
        chk_flag("fstart", 1, k < 3000);
        step(1);
    end
    endtask
    ////////////////////////////////////////////////////////////////
    // Sampled mid-cycle: the pop happens at the next rising edge
    always @(negedge clk)
        if (rx_valid && rx_ready && listen)
            chk_word("rx", rq.size() ? rq.pop_front() : 20'hFFFFF, {rx_kind, rx_data});
    always @(negedge clk)
        if (ovr && listen)
            n_ovr = n_ovr + 1;
    always @(got_tgl)
        if (listen)
            chk_word("tx", dq.size() ? dq.pop_front() : 20'hFFFFF, got);
    initial
    begin
        #(60000 * 40);
        chk_flag("wdog", 1, 0);
        tally_and_finish;
    end
    initial
    begin
        step(16);
        rst_n = 1'b1;
        for (i = 0; i < 5; i = i + 1)
        begin
            ctrl_sel = (i == 4);
            {st_hi, st_lo} = (i == 4) ? $random(seed) : i;
            {base, c1, c2, r} = {$random(seed), $random(seed)};
            slot = 4'h2 + {1'b0, st_hi, st_lo, 1'b0};
            frame;
            step(300);
            cap_wr = 1'b1;
            cap_data = c1;
            step(1);
            cap_ch2 = 1'b1;
            cap_data = c2;
            step(1);
            {cap_wr, cap_ch2, ctx_valid, ctx_data} = {3'h1, r};
            while (ctx_ready !== 1'b1)
                step(1);
            step(1);
            ctx_valid = 1'b0;
            frame;
            if (!ctrl_sel)
            begin
                rq.push_back({2'h3, base, 4'h0});
                dq.push_back({4'h1, r});
            end
            rq.push_back({2'h1, base, slot});
            if (i != 2)
                rq.push_back({2'h2, base, slot + 4'h1});
            dq.push_back({slot, c1});
            dq.push_back({slot + 4'h1, c2});
            n_ovr = 0;
            rx_ready = (i != 2);
            listen = 1'b1;
            frame;
            rx_ready = 1'b1;
            step(4);
            listen = 1'b0;
            chk_flag("ovr", i == 2, n_ovr);
            chk_flag("rxq", 0, rq.size());
            chk_flag("txq", 0, dq.size());
        end
        master = 1'b1;
        step(5000);
        chk_flag("bcoe", 0, bclk_oe_n);
        tally_and_finish;
    end
endmodule
